/* File: gpio_pin_query_command.sv */
// Pin query command handler with pin sampling and output drive.
// Assumes a packet layer that delivers one command at a time.
`timescale 1ns/1ps
`include "gpio_query_map.svh"
module gpio_pin_query_command #(
  parameter int NPINS = `NUM_PINS,
  parameter int SAMPLE_CYC = `SAMPLE_CYC,
  parameter int PWM_STEP_CYC = `PWM_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_type_i,
  input wire logic [7:0] cmd_len_i,
  input wire logic [7:0] cmd_data0_i,
  input wire logic [NPINS-1:0] pin_in_i,
  input wire logic [NPINS*8-1:0] duty_cfg_i,
  input wire logic [NPINS*4-1:0] pin_config_byte_i,
  input wire logic [NPINS-1:0] alt_out_i,
  input wire logic [NPINS-1:0] alt_oe_i,
  output logic reply_valid_o,
  output logic reply_error_o,
  output logic [7:0] reply_type_o,
  output logic [7:0] reply_len_o,
  output logic [31:0] reply_data_o,
  output logic [NPINS-1:0] pin_out_o,
  output logic [NPINS-1:0] pin_oe_o,
  output logic [NPINS-1:0] pin_pull_up_o,
  output logic [NPINS-1:0] pin_pull_dn_o,
  output logic [NPINS-1:0] pin_slow_o
);
  import gpio_query_pkg::*;

  typedef struct packed {
    logic [NPINS-1:0] sync1;
    logic [NPINS-1:0] sync2;
    logic [NPINS-1:0] level;
    logic [NPINS-1:0] rise;
    logic [NPINS-1:0] fall;
    logic seeded;
    logic [31:0] samp_cnt;
    logic [31:0] step_cnt;
    logic [6:0] phase;
    query_state_e state;
    logic rvalid;
    logic rerr;
    logic [7:0] rtype;
    logic [7:0] rlen;
    logic [31:0] rdata;
    logic [NPINS-1:0] pout;
    logic [NPINS-1:0] poe;
    logic [NPINS-1:0] pup;
    logic [NPINS-1:0] pdn;
    logic [NPINS-1:0] pslow;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Duty byte of one pin
  function automatic logic [7:0] duty_of(input logic [NPINS*8-1:0] v, input int i);
    duty_of = v[i*8 +: 8];
  endfunction

  // Config nibble of one pin
  function automatic logic [3:0] cfg_of(input logic [NPINS*4-1:0] v, input int i);
    cfg_of = v[i*4 +: 4];
  endfunction

  logic [7:0] idx;
  logic idx_ok;
  logic sample_tick;
  assign idx = cmd_data0_i;
  assign idx_ok = (idx < 8'(NPINS));
  assign sample_tick = (st_reg.samp_cnt == 32'(SAMPLE_CYC - 1));

  // Next state: sampling, PWM, drive decode and query reply
  always_comb begin
    logic want;
    logic [2:0] dm;
    logic [7:0] duty;
    logic [3:0] cf;
    want = 1'b0;
    dm = 3'h0;
    duty = 8'h00;
    cf = 4'h0;
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.rerr = 1'b0;
    // pin passes a two stage synchroniser
    st_next.sync1 = pin_in_i;
    st_next.sync2 = st_reg.sync1;
    st_next.samp_cnt = sample_tick ? 32'h0 : st_reg.samp_cnt + 32'h1;
    if (st_reg.step_cnt == 32'(PWM_STEP_CYC - 1)) begin
      st_next.step_cnt = 32'h0;
      st_next.phase = (st_reg.phase == 7'h63) ? 7'h0 : st_reg.phase + 7'h1;
    end else begin
      st_next.step_cnt = st_reg.step_cnt + 32'h1;
    end
    // clear edge flags of the queried pin
    if (cmd_valid_i && cmd_type_i == `CMD_QUERY && cmd_len_i == 8'h01 && idx_ok) begin
      for (int i = 0; i < NPINS; i++) begin
        if (idx == 8'(i)) begin
          st_next.rise[i] = 1'b0;
          st_next.fall[i] = 1'b0;
        end
      end
    end
    // edges only seen between samples, set wins over clear
    if (sample_tick) begin
      st_next.level = st_reg.sync2;
      // First sample after reset only seeds the level, so a pin idling high flags no edge
      if (st_reg.seeded) begin
        st_next.rise = st_next.rise | (st_reg.sync2 & ~st_reg.level);
        st_next.fall = st_next.fall | (~st_reg.sync2 & st_reg.level);
      end
      st_next.seeded = 1'b1;
    end
    // accept only a well formed query
    if (cmd_valid_i && cmd_type_i == `CMD_QUERY) begin
      st_next.state = ST_REPLY;
      st_next.rvalid = 1'b1;
      st_next.rtype = cmd_type_i | `REPLY_FLAG;
      if (idx_ok && cmd_len_i == 8'h01) begin
        st_next.rlen = `REPLY_LEN;
        st_next.rdata = 32'h0;
        st_next.rdata[7:0] = idx;
        for (int i = 0; i < NPINS; i++) begin
          if (idx == 8'(i)) begin
            st_next.rdata[8] = st_reg.level[i];
            st_next.rdata[9] = st_reg.fall[i];
            st_next.rdata[10] = st_reg.rise[i];
            st_next.rdata[23:16] = duty_of(duty_cfg_i, i);
            st_next.rdata[27:24] = cfg_of(pin_config_byte_i, i);
          end
        end
      end else begin
        st_next.rerr = 1'b1;
        st_next.rlen = 8'h00;
        st_next.rdata = 32'h0;
      end
    end else begin
      st_next.state = ST_IDLE;
    end
    // Pin drive per mode
    for (int i = 0; i < NPINS; i++) begin
      cf = cfg_of(pin_config_byte_i, i);
      dm = cf[2:0];
      duty = duty_of(duty_cfg_i, i);
      // user control uses duty and PWM
      want = (duty >= `DUTY_MAX) ? 1'b1 : ({1'b0, st_reg.phase} < duty);
      if (!cf[3]) begin
        want = alt_out_i[i];
      end
      st_next.pout[i] = want;
      st_next.poe[i] = 1'b0;
      st_next.pup[i] = 1'b0;
      st_next.pdn[i] = 1'b0;
      st_next.pslow[i] = 1'b0;
      case (drive_mode_field_e'(dm))
        // fast up with pull down, fast push pull
        DRV_UP_PD: begin
          st_next.poe[i] = want;
          st_next.pdn[i] = ~want;
        end
        DRV_PUSH_FAST: st_next.poe[i] = 1'b1;
        // input, pull up with fast low
        DRV_HIZ: st_next.poe[i] = 1'b0;
        DRV_PU_DN: begin
          st_next.poe[i] = ~want;
          st_next.pup[i] = want;
        end
        // slow up only, slow push pull
        DRV_UP_SLOW: begin
          st_next.poe[i] = want;
          st_next.pslow[i] = 1'b1;
        end
        DRV_PUSH_SLOW: begin
          st_next.poe[i] = 1'b1;
          st_next.pslow[i] = 1'b1;
        end
        DRV_DN_SLOW: begin
          st_next.poe[i] = ~want;
          st_next.pslow[i] = 1'b1;
        end
        default: st_next.poe[i] = 1'b0;
      endcase
      if (!cf[3] && !alt_oe_i[i]) begin
        st_next.poe[i] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reply_valid_o = st_reg.rvalid;
  assign reply_error_o = st_reg.rerr;
  assign reply_type_o = st_reg.rtype;
  assign reply_len_o = st_reg.rlen;
  assign reply_data_o = st_reg.rdata;
  assign pin_out_o = st_reg.pout;
  assign pin_oe_o = st_reg.poe;
  assign pin_pull_up_o = st_reg.pup;
  assign pin_pull_dn_o = st_reg.pdn;
  assign pin_slow_o = st_reg.pslow;

  logic good_q;
  assign good_q = cmd_valid_i && cmd_type_i == `CMD_QUERY && cmd_len_i == 8'h01 && idx_ok;

  property p_reply_type;
    @(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_type_i == `CMD_QUERY |=> reply_valid_o && reply_type_o == 8'h63;
  endproperty
  a_reply_type: assert property (p_reply_type) else $error("reply type wrong");

  property p_len_echo;
    @(posedge clk_i) disable iff (srst_i)
      good_q |=> reply_len_o == 8'h04 && reply_data_o[7:0] == $past(cmd_data0_i);
  endproperty
  a_len_echo: assert property (p_len_echo) else $error("reply length or echo wrong");

  property p_bad_index;
    @(posedge clk_i) disable iff (srst_i)
      cmd_valid_i && cmd_type_i == `CMD_QUERY && !idx_ok |=> reply_error_o && reply_len_o == 8'h00;
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("bad index not refused");

  property p_good_ok;
    @(posedge clk_i) disable iff (srst_i)
      good_q |=> !reply_error_o;
  endproperty
  a_good_ok: assert property (p_good_ok) else $error("valid index refused");

  property p_reserved;
    @(posedge clk_i) disable iff (srst_i)
      reply_valid_o |-> reply_data_o[31:28] == 4'h0 && reply_data_o[15:11] == 5'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_clear;
    @(posedge clk_i) disable iff (srst_i)
      good_q && cmd_data0_i == 8'h00 && !sample_tick |=> !st_reg.rise[0] && !st_reg.fall[0];
  endproperty
  a_clear: assert property (p_clear) else $error("edge flags kept");

  property p_rise;
    @(posedge clk_i) disable iff (srst_i)
      sample_tick && st_reg.seeded && st_reg.sync2[2] && !st_reg.level[2] |=> st_reg.rise[2];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge lost");

  property p_fall;
    @(posedge clk_i) disable iff (srst_i)
      sample_tick && st_reg.seeded && !st_reg.sync2[2] && st_reg.level[2] |=> st_reg.fall[2];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge lost");

  property p_hold;
    @(posedge clk_i) disable iff (srst_i)
      !sample_tick |=> st_reg.level == $past(st_reg.level);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved off tick");

  property p_no_reply;
    @(posedge clk_i) disable iff (srst_i)
      !(cmd_valid_i && cmd_type_i == `CMD_QUERY) |=> !reply_valid_o;
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("reply without query");

  property p_state;
    @(posedge clk_i) disable iff (srst_i)
      reply_valid_o |-> st_reg.state == ST_REPLY;
  endproperty
  a_state: assert property (p_state) else $error("reply outside reply state");

  // Well formed query naming pin 0
  sequence s_ask_pin0;
    good_q && cmd_data0_i == 8'h00;
  endsequence

  // Reply carrying pin 0 data
  sequence s_reply_pin0;
    reply_valid_o && !reply_error_o && reply_data_o[7:0] == 8'h00;
  endsequence

  property p_ask_reply;
    @(posedge clk_i) disable iff (srst_i)
      s_ask_pin0 |=> s_reply_pin0;
  endproperty
  a_ask_reply: assert property (p_ask_reply) else $error("pin 0 reply missing");

  property p_duty_echo;
    @(posedge clk_i) disable iff (srst_i)
      s_ask_pin0 |=> reply_data_o[23:16] == $past(duty_cfg_i[7:0]);
  endproperty
  a_duty_echo: assert property (p_duty_echo) else $error("duty not echoed");

  property p_push_high;
    @(posedge clk_i) disable iff (srst_i)
      pin_config_byte_i[3:0] == 4'h9 && duty_cfg_i[7:0] >= `DUTY_MAX
        |=> pin_oe_o[0] && pin_out_o[0];
  endproperty
  a_push_high: assert property (p_push_high) else $error("user pin not driven high");

  property p_hiz;
    @(posedge clk_i) disable iff (srst_i)
      pin_config_byte_i[3:0] == 4'ha |=> !pin_oe_o[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("input mode drives pin");
endmodule

/* File: gpio_query_map.svh */
// Constants for the pin query command handler.
// Assumes a packet layer outside that frames commands and replies.
// Notes on behaviour
// - Pin indices 0..4 valid, others not.
// - Reply type is request OR 0x40.
// - Four byte reply, first echoes index.
// - Byte one bit zero is sampled level.
// - Bit one flags falling edge since query.
// - Bit two flags rising edge since query.
// - Level comes from the physical pin.
// - Activity between samples may be missed.
// - Byte two returns requested duty percentage.
// - Byte three low nibble is config.
// - Codes 000 and 001 drive modes.
// - Codes 010 and 011 drive modes.
// - Codes 100 and 101 drive modes.
// - Code 111 open low, 110 reserved.
// - Function zero gives alternate pin function.
// - Function one gives user pin control.
// - Sample every pin at 32 Hz.
// - Mid duty uses 100 Hz PWM.
`ifndef GPIO_QUERY_MAP_SVH
`define GPIO_QUERY_MAP_SVH
`define CMD_QUERY 8'h23
`define REPLY_FLAG 8'h40
`define REPLY_LEN 8'h04
`define NUM_PINS 5
`define DUTY_MAX 8'h64
`define CLK_HZ 125000000
`define SAMPLE_HZ 32
`define PWM_HZ 100
`define SAMPLE_CYC (`CLK_HZ / `SAMPLE_HZ)
`define PWM_STEP_CYC (`CLK_HZ / (`PWM_HZ * 100))
`define CFG_RESET 4'h2
`endif

/* File: gpio_query_pkg.sv */
// Types for the pin query command handler.
// Assumes the constants header sits beside it.
package gpio_query_pkg;
  typedef enum logic [2:0] {
    DRV_UP_PD = 3'h0, DRV_PUSH_FAST = 3'h1, DRV_HIZ = 3'h2, DRV_PU_DN = 3'h3,
    DRV_UP_SLOW = 3'h4, DRV_PUSH_SLOW = 3'h5, DRV_RSVD = 3'h6, DRV_DN_SLOW = 3'h7
  } drive_mode_field_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REPLY = 2'b10
  } query_state_e;
endpackage

/* File: gpio_host_model.sv */
// Host-side model that frames one command packet per call.
// Assumes the handler takes a command at the rising clock edge.
`timescale 1ns/1ps
module gpio_host_model (
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_type_o,
  output logic [7:0] cmd_len_o,
  output logic [7:0] cmd_data0_o
);
  // Idle until the first request
  initial begin
    cmd_valid_o = 1'b0;
    cmd_type_o = 8'h00;
    cmd_len_o = 8'h00;
    cmd_data0_o = 8'h00;
  end

  task automatic send(input logic [7:0] typ, input logic [7:0] len, input logic [7:0] idx);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_type_o <= typ;
    cmd_len_o <= len;
    cmd_data0_o <= idx;
    @(posedge clk_i);
    // Released fields show junk so a stale value is never trusted
    cmd_valid_o <= 1'b0;
    cmd_type_o <= ~typ;
    cmd_len_o <= ~len;
    cmd_data0_o <= ~idx;
  endtask
endmodule

/* File: gpio_pin_query_command_tb.sv */
// Self-checking bench for the pin query command handler.
// Assumes short sample and PWM step counts set as parameters.
`timescale 1ns/1ps
module gpio_pin_query_command_tb;
  localparam int SCYC = 16;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  // Pin 4 idles high like a pulled-up line
  logic [4:0] pin_in = 5'h10, alt_out = 5'h00, alt_oe = 5'h00;
  logic [39:0] duty = 40'h0;
  logic [19:0] cfg = 20'h0;
  logic cmd_valid, rv, rerr;
  logic [7:0] cmd_type, cmd_len, cmd_data0, rtype, rlen;
  logic [31:0] rdata;
  logic [4:0] p_out, p_oe, p_pu, p_pd, p_slow;
  int err_count = 0, comparisons = 0, cycles = 0, cnt;
  logic [7:0] dv [5] = '{8'h00, 8'h01, 8'h32, 8'h63, 8'h64};
  logic [3:0] cv [5] = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hc};

  gpio_host_model i_gpio_host_model (.clk_i(clk_i), .cmd_valid_o(cmd_valid),
    .cmd_type_o(cmd_type), .cmd_len_o(cmd_len), .cmd_data0_o(cmd_data0));

  gpio_pin_query_command #(.SAMPLE_CYC(SCYC), .PWM_STEP_CYC(2)) i_gpio_pin_query_command (
    .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_type_i(cmd_type),
    .cmd_len_i(cmd_len), .cmd_data0_i(cmd_data0), .pin_in_i(pin_in), .duty_cfg_i(duty),
    .pin_config_byte_i(cfg), .alt_out_i(alt_out), .alt_oe_i(alt_oe), .reply_valid_o(rv),
    .reply_error_o(rerr), .reply_type_o(rtype), .reply_len_o(rlen), .reply_data_o(rdata),
    .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_pull_up_o(p_pu), .pin_pull_dn_o(p_pd),
    .pin_slow_o(p_slow));

  // 125 MHz clock
  initial forever #4 clk_i = ~clk_i;

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  // Good query, then header checks on the reply
  task automatic query(input logic [7:0] idx);
    i_gpio_host_model.send(8'h23, 8'h01, idx);
    #1;
    check({rv, rerr}, 2'b10, "valid");
    check(rtype, 8'h63, "type");
    check({rlen, rdata[7:0]}, {8'h04, idx}, "len idx");
  endtask

  // Expected {oe, out, pull up, pull down, slow} for a drive code
  function automatic logic [4:0] drv(input logic [2:0] m, input logic v);
    case (m)
      3'h0: drv = v ? 5'h18 : 5'h02;
      3'h1: drv = v ? 5'h18 : 5'h10;
      3'h3: drv = v ? 5'h04 : 5'h10;
      3'h4: drv = v ? 5'h19 : 5'h00;
      3'h5: drv = v ? 5'h19 : 5'h11;
      3'h7: drv = v ? 5'h00 : 5'h11;
      default: drv = 5'h00;
    endcase
  endfunction

  task automatic t_fields();
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      duty[8*i+:8] <= dv[i];
      cfg[4*i+:4] <= cv[i];
    end
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      query(i[7:0]);
      check(rdata[31:16], {4'h0, cv[i], dv[i]}, "duty cfg");
    end
    $display("test fields done");
  endtask

  task automatic t_bad();
    logic [7:0] ix [3] = '{8'h05, 8'hff, 8'h01};
    for (int i = 0; i < 3; i++) begin
      i_gpio_host_model.send(8'h23, (i == 2) ? 8'h02 : 8'h01, ix[i]);
      #1;
      check({14'h0, rv, rerr, rtype, rlen}, {14'h0, 2'b11, 8'h63, 8'h00}, "bad head");
      check(rdata, 32'h0, "bad data");
    end
    i_gpio_host_model.send(8'h22, 8'h01, 8'h00);
    #1;
    check(rv, 1'b0, "other type");
    $display("test bad done");
  endtask

  task automatic t_edges();
    @(posedge clk_i);
    cfg[11:8] <= 4'h9;
    duty[23:16] <= 8'h00;
    query(8'h04);
    check(rdata[11:8], 4'h1, "idle high");
    query(8'h02);
    @(posedge clk_i);
    pin_in[2] <= 1'b1;
    repeat (3 * SCYC) @(posedge clk_i);
    query(8'h02);
    check(rdata[11:8], 4'h5, "rise");
    query(8'h02);
    check(rdata[11:8], 4'h1, "cleared");
    @(posedge clk_i);
    pin_in[2] <= 1'b0;
    repeat (3 * SCYC) @(posedge clk_i);
    query(8'h02);
    check(rdata[11:8], 4'h2, "fall");
    $display("test edges done");
  endtask

  task automatic t_drive();
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      cfg[3:0] <= {1'b1, k[3:1]};
      duty[7:0] <= k[0] ? 8'h64 : 8'h00;
      repeat (6) @(posedge clk_i);
      check({p_oe[0], p_oe[0] & p_out[0], p_pu[0], p_pd[0], p_oe[0] & p_slow[0]},
        drv(k[3:1], k[0]), "drive");
    end
    duty[7:0] <= 8'h32;
    repeat (10) @(posedge clk_i);
    cnt = 0;
    repeat (200) begin
      @(negedge clk_i);
      cnt = cnt + int'(p_out[0]);
    end
    check(cnt, 100, "pwm");
    @(posedge clk_i);
    cfg[3:0] <= 4'h1;
    alt_oe[0] <= 1'b1;
    alt_out[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({p_oe[0], p_out[0]}, 2'b11, "alt high");
    alt_oe[0] <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(p_oe[0], 1'b0, "alt off");
    $display("test drive done");
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    t_fields();
    t_bad();
    t_edges();
    t_drive();
    report_and_stop();
  end
endmodule
